// [rtl/fwpr_cfg.svh]
// fwpr_cfg.svh: offsets, field positions, reset values of the flash
// write protection block; assumes byte addresses on a 32-bit bus.
`ifndef FWPR_CFG_SVH
`define FWPR_CFG_SVH

`define FWPR_OFF_PROT 8'h00
`define FWPR_OFF_STAT 8'h04
`define FWPR_OFF_IST 8'h08
`define FWPR_OFF_IMASK 8'h0C
`define FWPR_OFF_CMD 8'h10

`define FWPR_OPEN_BIT 0
`define FWPR_SIZE_HI 7
`define FWPR_SIZE_LO 1
`define FWPR_VIOL_BIT 5
`define FWPR_EV_VIOL 0
`define FWPR_EV_ISSUE 1
`define FWPR_CMD_KIND_HI 25
`define FWPR_CMD_KIND_LO 24
`define FWPR_SECT_LSB 11

`define FWPR_PROT_RST 8'h00
`define FWPR_EV_RST 2'h0
`define FWPR_FULL_UNITS 8'h80
`define FWPR_OPEN_UNITS 7'h7F

`endif

// [rtl/fwpr_pkg.sv]
// fwpr_pkg: types and the protected-span decode of the protection block;
// assumes fwpr_cfg.svh is on the include path.
`include "fwpr_cfg.svh"

package fwpr_pkg;

  typedef enum logic [0:0] {
    FWPR_BUS_IDLE = 1'b0,
    FWPR_BUS_ACK = 1'b1
  } fwpr_bus_t;

  typedef enum logic [1:0] {
    FWPR_CMD_NONE = 2'b00,
    FWPR_CMD_PROG = 2'b01,
    FWPR_CMD_SECT = 2'b10,
    FWPR_CMD_MASS = 2'b11
  } fwpr_cmd_t;

  // protected span in 2 KB units counted up from the array base
  function automatic logic [7:0] fwpr_units(input logic [7:0] v);
    if (!v[`FWPR_OPEN_BIT]) begin
      return `FWPR_FULL_UNITS;
    end
    return {1'b0, `FWPR_OPEN_UNITS - v[`FWPR_SIZE_HI:`FWPR_SIZE_LO]};
  endfunction

endpackage

// [rtl/fwpr_limit.sv]
// fwpr_limit: decides whether an array offset lies in the protected span;
// assumes the protection byte and offset are stable in the same cycle.
`timescale 1ns/10ps
`include "fwpr_cfg.svh"

module fwpr_limit (
  // protection byte
  input wire logic [7:0] prot_i,
  // array offset from base
  input wire logic [17:0] offset_i,
  // decode results
  output logic hit_o,
  output logic any_o
);

  logic [7:0] units;

  always_comb begin
    units = fwpr_pkg::fwpr_units(prot_i);
    // offset below limit means sector index below span
    hit_o = {1'b0, offset_i[17:`FWPR_SECT_LSB]} < units;
    any_o = units != 8'h00;
  end

endmodule

// [rtl/fwpr_top.sv]
// Contract
// - with the open bit clear the whole 256 KB array counts as protected.
// - with the open bit set the size field gives a span from the base, 0x00 being 254 KB, 2 KB less per step, 0x7F none.
// - the protection register is one byte, size field in bits 7 to 1 and the open bit in bit 0.
// - a write to the protection register takes effect only if it does not shrink the span.
// - after reset the protection register is loaded from the stored protection byte.
// - a program or erase aimed at a protected offset is not issued and sets the violation flag.
// - a mass erase is refused while any sector is protected.
// - the violation flag clears only by writing one to it, and while set no command is launched.
//
// fwpr_top: flash write protection with a classic Wishbone slave;
// assumes a single-beat master and the array holding stored_prot_i stable.
`timescale 1ns/10ps
`include "fwpr_cfg.svh"

module fwpr_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // stored protection byte from the configuration field
  input wire logic [7:0] stored_prot_i,
  // command towards the array
  output logic cmd_valid_o,
  output logic [1:0] cmd_kind_o,
  output logic [17:0] cmd_addr_o,
  // interrupt
  output logic irq_o
);

  fwpr_pkg::fwpr_bus_t bus_state;
  fwpr_pkg::fwpr_bus_t next_bus_state;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;

  logic [7:0] prot;
  logic [7:0] next_prot;
  logic loaded;
  logic next_loaded;
  logic viol;
  logic next_viol;
  logic [1:0] ist;
  logic [1:0] next_ist;
  logic [1:0] imask;
  logic [1:0] next_imask;
  logic next_irq;

  logic next_cmd_valid;
  logic [1:0] next_cmd_kind;
  logic [17:0] next_cmd_addr;

  logic req;
  logic wr_en;
  logic prot_wr;
  logic cmd_wr;
  logic stat_wr;
  logic ist_wr;
  logic imask_wr;
  logic hit;
  logic any_prot;
  logic set_viol;
  logic issue;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [1:0] wr_kind;
  logic [17:0] wr_off;

  fwpr_limit u_limit (
    .prot_i(prot),
    .offset_i(wr_off),
    .hit_o(hit),
    .any_o(any_prot)
  );

  // bus decode
  always_comb begin
    req = wb_cyc_i && wb_stb_i && (bus_state == fwpr_pkg::FWPR_BUS_IDLE);
    wr_en = req && wb_we_i;
    prot_wr = wr_en && wb_sel_i[0] && (wb_adr_i == `FWPR_OFF_PROT);
    stat_wr = wr_en && wb_sel_i[0] && (wb_adr_i == `FWPR_OFF_STAT);
    ist_wr = wr_en && wb_sel_i[0] && (wb_adr_i == `FWPR_OFF_IST);
    imask_wr = wr_en && wb_sel_i[0] && (wb_adr_i == `FWPR_OFF_IMASK);
    // partial writes to the command word would launch half a command
    cmd_wr = wr_en && (wb_sel_i == 4'hF) && (wb_adr_i == `FWPR_OFF_CMD);
    wr_kind = wb_dat_i[`FWPR_CMD_KIND_HI:`FWPR_CMD_KIND_LO];
    wr_off = wb_dat_i[17:0];
  end

  // bus state and read data
  always_comb begin
    next_bus_state = bus_state;
    next_wb_ack = 1'b0;
    next_wb_dat = wb_dat_o;
    case (bus_state)
      fwpr_pkg::FWPR_BUS_IDLE: begin
        if (req) begin
          next_bus_state = fwpr_pkg::FWPR_BUS_ACK;
          next_wb_ack = 1'b1;
          next_wb_dat = 32'h0000_0000;
          if (!wb_we_i) begin
            case (wb_adr_i)
              `FWPR_OFF_PROT: next_wb_dat = {24'h00_0000, prot};
              `FWPR_OFF_STAT: begin
                next_wb_dat[`FWPR_VIOL_BIT] = viol;
              end
              `FWPR_OFF_IST: next_wb_dat = {30'h0000_0000, ist};
              `FWPR_OFF_IMASK: next_wb_dat = {30'h0000_0000, imask};
              default: next_wb_dat = 32'h0000_0000;
            endcase
          end
        end
      end
      fwpr_pkg::FWPR_BUS_ACK: begin
        next_bus_state = fwpr_pkg::FWPR_BUS_IDLE;
      end
      default: begin
        next_bus_state = fwpr_pkg::FWPR_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= fwpr_pkg::FWPR_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      wb_ack_o <= next_wb_ack;
      wb_dat_o <= next_wb_dat;
    end
  end

  // protection byte
  always_comb begin
    next_prot = prot;
    next_loaded = 1'b1;
    if (!loaded) begin
      // first edge after release, load wins over a bus write
      next_prot = stored_prot_i;
    end else if (prot_wr) begin
      if (fwpr_pkg::fwpr_units(wb_dat_i[7:0]) >=
          fwpr_pkg::fwpr_units(prot)) begin
        next_prot = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // fully protected until the stored byte arrives
      prot <= `FWPR_PROT_RST;
      loaded <= 1'b0;
    end else begin
      prot <= next_prot;
      loaded <= next_loaded;
    end
  end

  // command check and violation flag
  always_comb begin
    set_viol = 1'b0;
    issue = 1'b0;
    next_cmd_valid = 1'b0;
    next_cmd_kind = cmd_kind_o;
    next_cmd_addr = cmd_addr_o;
    if (cmd_wr && !viol && loaded &&
        (wr_kind != fwpr_pkg::FWPR_CMD_NONE)) begin
      if (wr_kind == fwpr_pkg::FWPR_CMD_MASS) begin
        set_viol = any_prot;
      end else begin
        set_viol = hit;
      end
      issue = !set_viol;
    end
    if (issue) begin
      next_cmd_valid = 1'b1;
      next_cmd_kind = wr_kind;
      next_cmd_addr = (wr_kind == fwpr_pkg::FWPR_CMD_MASS) ?
                      18'h0_0000 : wr_off;
    end
    // set wins over a same-cycle clear
    next_viol = viol;
    if (stat_wr && wb_dat_i[`FWPR_VIOL_BIT]) begin
      next_viol = 1'b0;
    end
    if (set_viol) begin
      next_viol = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      viol <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_kind_o <= 2'h0;
      cmd_addr_o <= 18'h0_0000;
    end else begin
      viol <= next_viol;
      cmd_valid_o <= next_cmd_valid;
      cmd_kind_o <= next_cmd_kind;
      cmd_addr_o <= next_cmd_addr;
    end
  end

  // interrupt status, mask and line
  always_comb begin
    ev_set = `FWPR_EV_RST;
    ev_set[`FWPR_EV_VIOL] = set_viol;
    ev_set[`FWPR_EV_ISSUE] = issue;
    ev_clr = ist_wr ? wb_dat_i[1:0] : 2'h0;
    next_ist = (ist & ~ev_clr) | ev_set;
    next_imask = imask_wr ? wb_dat_i[1:0] : imask;
    next_irq = |(ist & imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist <= `FWPR_EV_RST;
      imask <= `FWPR_EV_RST;
      irq_o <= 1'b0;
    end else begin
      ist <= next_ist;
      imask <= next_imask;
      irq_o <= next_irq;
    end
  end

  // independent span check for span_outside_a below
  logic [6:0] chk_units;
  assign chk_units = `FWPR_OPEN_UNITS - cmd_addr_o[17:`FWPR_SECT_LSB];

  ack_one_beat_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  ack_follows_req_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o
  ) else $error("request not answered in one cycle");

  closed_blocks_all_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_o |-> prot[`FWPR_OPEN_BIT]
  ) else $error("command issued while array fully protected");

  span_outside_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_o && (cmd_kind_o != fwpr_pkg::FWPR_CMD_MASS) |->
      (prot[`FWPR_SIZE_HI:`FWPR_SIZE_LO] >= chk_units)
  ) else $error("command issued inside protected span");

  read_back_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && (wb_adr_i == `FWPR_OFF_PROT) |=>
      wb_dat_o == {24'h00_0000, $past(prot)}
  ) else $error("protection byte read back wrong");

  // equal spans may be rewritten: closed values all decode to 256 KB
  no_shrink_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    loaded && $past(loaded) && (prot != $past(prot)) |->
      fwpr_pkg::fwpr_units(prot) >= fwpr_pkg::fwpr_units($past(prot))
  ) else $error("protected span shrank");

  reset_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !loaded |=> loaded && (prot == $past(stored_prot_i))
  ) else $error("stored byte not loaded after reset");

  hit_flags_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_wr && loaded && !viol && hit &&
      (wr_kind == fwpr_pkg::FWPR_CMD_PROG) |=>
      viol && !cmd_valid_o ##1 viol
  ) else $error("protected program not flagged");

  mass_refused_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_o && (cmd_kind_o == fwpr_pkg::FWPR_CMD_MASS) |->
      $past(prot) == 8'hFF
  ) else $error("mass erase issued while protected");

  viol_sticky_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    viol && !(stat_wr && wb_dat_i[`FWPR_VIOL_BIT]) |=> viol
  ) else $error("violation flag cleared without a one");

  viol_blocks_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    viol && cmd_wr |=> !cmd_valid_o
  ) else $error("command launched while violation set");

  irq_level_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> irq_o == |($past(ist) & $past(imask))
  ) else $error("interrupt line does not follow status");

endmodule

// [dv/fwpr_array_model.sv]
// fwpr_array_model: array stand-in holding the stored protection byte;
// assumes commands arrive as one-cycle pulses from fwpr_top.
`timescale 1ns/10ps

module fwpr_array_model #(
  parameter logic [6:0] CFG_SECT = 7'h7F
) (
  // clock
  input wire logic clk_i,
  // commands from the block
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_kind_i,
  input wire logic [17:0] cmd_addr_i,
  // value a program of the config sector stores
  input wire logic [7:0] new_byte_i,
  // stored protection byte
  output logic [7:0] stored_prot_o
);
  // nonvolatile, so reset leaves it alone; starts erased
  initial stored_prot_o = 8'hFF;
  always @(posedge clk_i) begin
    if (cmd_valid_i && cmd_kind_i == 2'h3) begin
      stored_prot_o <= 8'hFF;
    end else if (cmd_valid_i && cmd_addr_i[17:11] == CFG_SECT) begin
      stored_prot_o <= (cmd_kind_i == 2'h1) ? new_byte_i : 8'hFF;
    end
  end
endmodule

// [dv/tb.sv]
// tb: self-checking bench of fwpr_top over classic wishbone;
// assumes the array model sits on the command port.
`timescale 1ns/10ps

module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, nb = 8'h00, p, stored, sp, b;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, cmd_valid_o, irq_o, viol;
  logic [1:0] cmd_kind_o, ist, mask, k;
  logic [17:0] cmd_addr_o;
  logic [6:0] s;
  logic [31:0] exp_rd[$];
  logic [19:0] exp_cmd[$];
  int miscompares = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  fwpr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stored_prot_i(sp), .cmd_valid_o(cmd_valid_o),
    .cmd_kind_o(cmd_kind_o), .cmd_addr_o(cmd_addr_o), .irq_o(irq_o));
  fwpr_array_model i_mem (.clk_i(clk_i), .cmd_valid_i(cmd_valid_o),
    .cmd_kind_i(cmd_kind_o), .cmd_addr_i(cmd_addr_o), .new_byte_i(nb),
    .stored_prot_o(sp));
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // an empty queue turns an unasked result into a miscompare
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk(exp_rd.size() ? exp_rd.pop_front() : 32'hFFFF_FFFF, wb_dat_o);
    end
    if (cmd_valid_o === 1'b1) begin
      chk(exp_cmd.size() ? {12'h0, exp_cmd.pop_front()} : 32'hFFFF_FFFF,
        {12'h0, cmd_kind_o, cmd_addr_o});
    end
  end
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] sl);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      summarize();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  function automatic logic [7:0] units(input logic [7:0] v);
    return v[0] ? {1'b0, 7'h7F - v[7:1]} : 8'h80;
  endfunction
  task automatic wr_prot(input logic [7:0] v);
    wb(1'b1, 8'h00, {24'h0, v}, 4'hF);
    if (units(v) >= units(p)) p = v;
    rd(8'h00, {24'h0, p});
  endtask
  task automatic cmd(input logic [1:0] kd, input logic [17:0] o);
    logic hit;
    hit = kd == 2'h3 ? units(p) != 8'h0 : {1'b0, o[17:11]} < units(p);
    if (viol || kd == 2'h0) begin
    end else if (hit) begin
      viol = 1'b1;
      ist[0] = 1'b1;
    end else begin
      exp_cmd.push_back({kd, o});
      ist[1] = 1'b1;
      if (kd == 2'h3 || o[17:11] == 7'h7F) stored = kd == 2'h1 ? nb : 8'hFF;
    end
    wb(1'b1, 8'h10, {6'h0, kd, 6'h0, o}, 4'hF);
    // irq_o seen here was registered one edge after the status bit
    chk({31'h0, |(ist & mask)}, {31'h0, irq_o});
    rd(8'h04, {26'h0, viol, 5'h0});
  endtask
  task automatic clr();
    wb(1'b1, 8'h04, 32'h20, 4'hF);
    wb(1'b1, 8'h08, 32'h3, 4'hF);
    viol = 1'b0;
    ist = 2'h0;
    chk(32'h0, {31'h0, irq_o});
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    p = stored;
    viol = 1'b0;
    ist = 2'h0;
    mask = 2'($urandom);
    rd(8'h00, {24'h0, p});
    wb(1'b1, 8'h0C, {30'h0, mask}, 4'hF);
  endtask
  initial begin
    void'($urandom(63772));
    stored = 8'hFF;
    do_reset();
    rd(8'h08, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h10, 32'h0);
    cmd(2'h3, 18'h0);
    mask = 2'h3;
    wb(1'b1, 8'h0C, 32'h3, 4'hF);
    nb = 8'h7B;
    cmd(2'h1, 18'h3_F800);
    wr_prot(8'hFD);
    cmd(2'h1, 18'h0_07FF);
    wb(1'b1, 8'h04, 32'h0, 4'hF);
    cmd(2'h1, 18'h0_0800);
    clr();
    cmd(2'h1, 18'h0_0800);
    wb(1'b1, 8'h10, 32'h0100_1000, 4'h1);
    wr_prot(8'hFF);
    wr_prot(8'hFE);
    cmd(2'h2, 18'h3_FFFF);
    clr();
    // reload picks up the reprogrammed byte
    for (int i = 0; i < 200; i++) begin
      if (i % 25 == 0) do_reset();
      nb = 8'($urandom);
      b = 8'($urandom) | {7'h0, 1'($urandom % 8 != 0)};
      wr_prot(b);
      k = 2'($urandom);
      s = 7'(units(p) + $urandom % 3 - 1);
      cmd(k, k == 2'h3 ? 18'h0 : {s, 11'($urandom)});
      if (viol) clr();
    end
    chk(32'h0, 32'(exp_rd.size() + exp_cmd.size()));
    summarize();
  end
endmodule
